/* core/asfpc_fifo.sv */
// parameterised valid/ready fifo for conversion results
`timescale 1ns/1ps
module asfpc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE = (AW+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = clk_en & s_valid & s_ready;
    wire pop = clk_en & m_valid & m_ready;

    assign s_ready = (count != DEPTH_CNT);
    assign m_valid = (count != '0);
    assign m_data = mem[rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= s_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'((32'(wr_ptr) + 1) % DEPTH);
            end
            if (pop) begin
                rd_ptr <= AW'((32'(rd_ptr) + 1) % DEPTH);
            end
            if (push && !pop) begin
                count <= count + ONE;
            end else if (pop && !push) begin
                count <= count - ONE;
            end
        end
    end
endmodule // asfpc_fifo

/* core/asfpc_frame.sv */
// serial frame, abort and power-down control of the converter
`timescale 1ns/1ps
module asfpc_frame (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // serial link pins
    input wire asfpc_pkg::asfpc_link_in_t link_in,
    output asfpc_pkg::asfpc_link_out_t link_out,
    // results from the converter core
    input wire logic result_valid,
    output logic result_ready,
    input wire asfpc_pkg::asfpc_word_t result,
    // control towards the converter core
    output asfpc_pkg::asfpc_status_t status
);
    localparam int WAKE_END = asfpc_pkg::WAKE_CYCLES - 1;

    // three-stage synchronisers, bit 0 read only by bit 1
    logic [asfpc_pkg::SYNC_STAGES-1:0] cs_sync;
    logic [asfpc_pkg::SYNC_STAGES-1:0] sclk_sync;
    logic [asfpc_pkg::SYNC_STAGES-1:0] pd_sync;
    logic cs_lvl;
    logic sclk_lvl;
    logic pd_lvl;

    asfpc_pkg::asfpc_frame_t frame_state;
    asfpc_pkg::asfpc_pwr_t pwr_state;
    logic [asfpc_pkg::CNT_W-1:0] fall_cnt;
    logic [asfpc_pkg::CNT_W-1:0] wake_cnt;
    logic [asfpc_pkg::FRAME_W-1:0] shift_reg;
    logic [asfpc_pkg::RESULT_W-1:0] held_word;
    logic seen_rise;
    logic mode32;
    logic pd_armed;
    logic drive;
    logic sample_pulse;
    logic abort_pulse;
    logic step_pulse;

    // edge decode on the agreeing stages
    wire cs_agree = (cs_sync[1] == cs_sync[2]);
    wire sclk_agree = (sclk_sync[1] == sclk_sync[2]);
    wire cs_fall = cs_agree & ~cs_sync[2] & cs_lvl;
    wire cs_rise = cs_agree & cs_sync[2] & ~cs_lvl;
    wire sclk_rise = sclk_agree & sclk_sync[2] & ~sclk_lvl;
    wire sclk_fall = sclk_agree & ~sclk_sync[2] & sclk_lvl;
    wire pd_agree = (pd_sync[1] == pd_sync[2]);

    // frame events
    wire act_fall = sclk_fall & ~cs_lvl & seen_rise;
    wire [asfpc_pkg::CNT_W-1:0] cnt_inc = fall_cnt + asfpc_pkg::CNT_ONE;
    wire cnt_sat = (fall_cnt == asfpc_pkg::FALL_MAX);
    wire at16 = act_fall & (cnt_inc == asfpc_pkg::FALL_CONV_DONE);
    wire at30 = act_fall & (cnt_inc == asfpc_pkg::FALL_MODE32);
    wire in_conv = (frame_state == asfpc_pkg::FRM_CONVERT);
    wire early = (fall_cnt < asfpc_pkg::FALL_CONV_DONE);
    wire abort_ev = cs_rise & in_conv & early;
    wire keep16 = cs_rise & ~early & (fall_cnt < asfpc_pkg::FALL_KEEP16);

    // word selection for frame start and for the 16th edge
    wire fifo_valid;
    wire [asfpc_pkg::RESULT_W-1:0] fifo_data;
    wire [asfpc_pkg::RESULT_W-1:0] fresh_word =
        fifo_valid ? fifo_data : held_word;
    wire [asfpc_pkg::FRAME_W-1:0] start_word =
        mode32 ? asfpc_pkg::FRAME_ZERO : {held_word, asfpc_pkg::PAD_ZERO};
    wire [asfpc_pkg::FRAME_W-1:0] fresh_frame =
        {fresh_word, asfpc_pkg::PAD_ZERO};
    wire [asfpc_pkg::FRAME_W-1:0] shifted =
        {shift_reg[asfpc_pkg::FRAME_W-2:0], 1'b0};

    // power transitions
    wire go_down = (pwr_state == asfpc_pkg::PWR_ACTIVE) & pd_armed & at16;
    wire wake32 = mode32 & sclk_rise & cs_lvl;
    wire wake16 = ~mode32 & cs_rise & ~pd_lvl;
    wire wake_done = (wake_cnt == asfpc_pkg::WAKE_LAST);

    asfpc_fifo #(
        .WIDTH(asfpc_pkg::RESULT_W),
        .DEPTH(asfpc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .s_valid(result_valid),
        .s_ready(result_ready),
        .s_data(result.code),
        .m_valid(fifo_valid),
        .m_ready(at16),
        .m_data(fifo_data)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_sync <= '1;
            sclk_sync <= '0;
            pd_sync <= '0;
            cs_lvl <= 1'b1;
            sclk_lvl <= 1'b0;
            pd_lvl <= 1'b0;
        end else if (clk_en) begin
            cs_sync <= {cs_sync[1:0], link_in.cs_n};
            sclk_sync <= {sclk_sync[1:0], link_in.sclk};
            pd_sync <= {pd_sync[1:0], link_in.power_down_request_pin};
            if (cs_agree) begin
                cs_lvl <= cs_sync[2];
            end
            if (sclk_agree) begin
                sclk_lvl <= sclk_sync[2];
            end
            if (pd_agree) begin
                pd_lvl <= pd_sync[2];
            end
        end
    end

    // frame sequencing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_state <= asfpc_pkg::FRM_ACQUIRE;
            fall_cnt <= asfpc_pkg::CNT_ZERO;
            seen_rise <= 1'b0;
        end else if (clk_en) begin
            if (cs_rise) begin
                frame_state <= asfpc_pkg::FRM_ACQUIRE;
            end else begin
                case (frame_state)
                    asfpc_pkg::FRM_ACQUIRE: begin
                        if (cs_fall) begin
                            frame_state <= asfpc_pkg::FRM_CONVERT;
                        end
                    end
                    asfpc_pkg::FRM_CONVERT: begin
                        if (at16) begin
                            frame_state <= asfpc_pkg::FRM_TRAIL;
                        end
                    end
                    asfpc_pkg::FRM_TRAIL: begin
                    end
                    default: begin
                        frame_state <= asfpc_pkg::FRM_ACQUIRE;
                    end
                endcase
            end
            if (cs_fall) begin
                fall_cnt <= asfpc_pkg::CNT_ZERO;
                seen_rise <= 1'b0;
            end else begin
                if (sclk_rise && !cs_lvl) begin
                    seen_rise <= 1'b1;
                end
                if (act_fall && !cnt_sat) begin
                    fall_cnt <= cnt_inc;
                end
            end
        end
    end

    // data path: shift register, held result, output drive
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_reg <= asfpc_pkg::FRAME_ZERO;
            held_word <= asfpc_pkg::RESULT_RESET;
            drive <= 1'b0;
        end else if (clk_en) begin
            if (cs_rise) begin
                drive <= 1'b0;
            end else if (cs_fall) begin
                drive <= 1'b1;
                shift_reg <= start_word;
            end else if (at16) begin
                // aborted frames never reach here, so held stays stale
                held_word <= fresh_word;
                shift_reg <= fresh_frame;
            end else if (act_fall) begin
                shift_reg <= shifted;
            end
        end
    end

    // framing mode and power-down request latch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode32 <= 1'b0;
            pd_armed <= 1'b0;
        end else if (clk_en) begin
            if (at30) begin
                mode32 <= 1'b1;
            end else if (keep16) begin
                mode32 <= 1'b0;
            end
            if (cs_rise) begin
                pd_armed <= pd_lvl;
            end
        end
    end

    // power state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pwr_state <= asfpc_pkg::PWR_ACTIVE;
            wake_cnt <= asfpc_pkg::CNT_ZERO;
        end else if (clk_en) begin
            case (pwr_state)
                asfpc_pkg::PWR_ACTIVE: begin
                    if (go_down) begin
                        pwr_state <= asfpc_pkg::PWR_DOWN;
                    end
                end
                asfpc_pkg::PWR_DOWN: begin
                    wake_cnt <= asfpc_pkg::CNT_ZERO;
                    if (wake32 || wake16) begin
                        pwr_state <= asfpc_pkg::PWR_WAKE;
                    end
                end
                asfpc_pkg::PWR_WAKE: begin
                    // warm-up the host must cover with cs high time
                    if (wake_done) begin
                        pwr_state <= asfpc_pkg::PWR_ACTIVE;
                    end else begin
                        wake_cnt <= wake_cnt + asfpc_pkg::CNT_ONE;
                    end
                end
                default: begin
                    pwr_state <= asfpc_pkg::PWR_ACTIVE;
                end
            endcase
        end
    end

    // registered strobes towards the converter core
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sample_pulse <= 1'b0;
            abort_pulse <= 1'b0;
            step_pulse <= 1'b0;
        end else if (clk_en) begin
            sample_pulse <= cs_fall;
            abort_pulse <= abort_ev;
            step_pulse <= act_fall & in_conv & ~cs_rise;
        end
    end

    assign link_out.sdo = shift_reg[asfpc_pkg::FRAME_W-1];
    assign link_out.sdo_oe = drive;
    assign status.sample = sample_pulse;
    assign status.abort = abort_pulse;
    assign status.conv_step = step_pulse;
    assign status.converting = in_conv;
    assign status.mode32 = mode32;
    assign status.power_down = (pwr_state == asfpc_pkg::PWR_DOWN);
    assign status.core_ready = (pwr_state == asfpc_pkg::PWR_ACTIVE);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_frame_start;
        clk_en && cs_fall;
    endsequence

    sequence s_sixteenth;
        clk_en && at16 && !cs_rise;
    endsequence

    property p_start_drive;
        s_frame_start |=> drive && in_conv && sample_pulse;
    endproperty
    a_start_drive: assert property (p_start_drive)
        else $error("frame start did not drive output");

    property p_release;
        clk_en && cs_rise |=> !drive ##1 !drive || !cs_lvl;
    endproperty
    a_release: assert property (p_release)
        else $error("output driven with cs high");

    property p_fresh_load;
        s_sixteenth |=> link_out.sdo == $past(fresh_word[13])
            && held_word == $past(fresh_word);
    endproperty
    a_fresh_load: assert property (p_fresh_load)
        else $error("fresh result not loaded at edge 16");

    property p_mode32_set;
        clk_en && at30 |=> mode32;
    endproperty
    a_mode32_set: assert property (p_mode32_set)
        else $error("32-clock framing not detected");

    property p_zero_start;
        s_frame_start ##0 mode32 |=> shift_reg == asfpc_pkg::FRAME_ZERO;
    endproperty
    a_zero_start: assert property (p_zero_start)
        else $error("32-clock frame did not start with zeros");

    property p_abort;
        clk_en && abort_ev |=> abort_pulse && !in_conv && !drive;
    endproperty
    a_abort: assert property (p_abort)
        else $error("early cs rise did not abort");

    property p_pd_latch;
        clk_en && cs_rise |=> pd_armed == $past(pd_lvl);
    endproperty
    a_pd_latch: assert property (p_pd_latch)
        else $error("power-down request not latched at cs rise");

    property p_pd_hold;
        clk_en && !cs_rise |=> pd_armed == $past(pd_armed);
    endproperty
    a_pd_hold: assert property (p_pd_hold)
        else $error("power-down request changed outside cs rise");

    property p_go_down;
        clk_en && go_down |=> status.power_down;
    endproperty
    a_go_down: assert property (p_go_down)
        else $error("power-down not entered after edge 16");

    property p_shift;
        clk_en && act_fall && !at16 && !cs_rise |=>
            link_out.sdo == $past(shift_reg[14]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("next bit not presented on falling edge");

    property p_stay_down;
        status.power_down && !cs_lvl && !cs_rise |=> status.power_down;
    endproperty
    a_stay_down: assert property (p_stay_down)
        else $error("left power-down with cs low");

    property p_wake_len;
        status.core_ready && $past(pwr_state) == asfpc_pkg::PWR_WAKE |->
            $past(wake_cnt) == WAKE_END;
    endproperty
    a_wake_len: assert property (p_wake_len)
        else $error("warm-up shorter than required");

    property p_keep16;
        clk_en && keep16 && !at30 |=> !mode32;
    endproperty
    a_keep16: assert property (p_keep16)
        else $error("16-clock framing not kept");
endmodule // asfpc_frame

/* pkg/asfpc_pkg.sv */
// constants and types of the serial frame and power control block
// Behaviour
// - cs held past 16th falling edge: shift out the fresh result from there
// - cs low through 30th falling edge switches framing to 32 clocks
// - in a 32-clock frame the current result is out before edge 30
// - after 32-clock detection the next frame starts with 16 zero bits
// - cs rise in first 16 clocks aborts conversion, restarts acquisition
// - after abort, next cs fall samples, converts; frame data invalid
// - abort in frame n: frame n+1 data invalid, its result in n+2
// - power-down request pin sampled only at cs rising edge, one cycle
// - with power-down armed, enter power-down right after 16th falling edge
// - while powered down, remaining data bits keep shifting normally
// - 32-clock power-down: wake on sclk rising edge, then 1 us warm-up
// - 16-clock burst: stay down while cs low, leave on cs rise, pin low
// - cs falling edge samples input, drives data output, presents msb
// - after first sclk rise, each falling edge presents the next lower bit
// - cs rise between 16th and 29th falling edge keeps 16-clock framing
// - data output is high impedance while cs is high
package asfpc_pkg;
    localparam int RESULT_W = 14;
    localparam int FRAME_W = 16;
    localparam int PAD_W = FRAME_W - RESULT_W;
    localparam int CNT_W = 6;
    localparam int SYNC_STAGES = 3;
    localparam int FIFO_DEPTH = 16;
    localparam logic [CNT_W-1:0] FALL_CONV_DONE = 6'h10;
    localparam logic [CNT_W-1:0] FALL_KEEP16 = 6'h1d;
    localparam logic [CNT_W-1:0] FALL_MODE32 = 6'h1e;
    localparam logic [CNT_W-1:0] FALL_MAX = 6'h20;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [PAD_W-1:0] PAD_ZERO = 2'h0;
    localparam logic [FRAME_W-1:0] FRAME_ZERO = 16'h0000;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 14'h0000;
    // warm-up time after leaving power-down, least time rounds up
    localparam int WAKE_TIME_NS = 1000;
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int WAKE_CYCLES =
        (WAKE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);

    typedef enum logic [1:0] {
        FRM_ACQUIRE = 2'h0,
        FRM_CONVERT = 2'h1,
        FRM_TRAIL = 2'h2
    } asfpc_frame_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_DOWN = 2'h1,
        PWR_WAKE = 2'h2
    } asfpc_pwr_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic power_down_request_pin;
    } asfpc_link_in_t;

    typedef struct packed {
        logic sdo;
        logic sdo_oe;
    } asfpc_link_out_t;

    typedef struct packed {
        logic [RESULT_W-1:0] code;
    } asfpc_word_t;

    typedef struct packed {
        logic sample;
        logic abort;
        logic conv_step;
        logic converting;
        logic mode32;
        logic power_down;
        logic core_ready;
    } asfpc_status_t;
endpackage

/* tb/asfpc_host.sv */
// host model that drives serial frames into the converter block
`timescale 1ns/1ps
module asfpc_host #(
    parameter int min_acquisition_time = 80
) (
    // serial link
    output asfpc_pkg::asfpc_link_in_t link_in,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // a released line reads as the inverse of the last bit
    wire logic sdo_line;
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    initial begin
        link_in.cs_n = 1'b1;
        link_in.sclk = 1'b0;
        link_in.power_down_request_pin = 1'b0;
    end

    // one frame of n falls; pin shows the opposite of pd until sclk stops, then pd for 100 ns before cs rises
    task automatic frame(input int n, input logic pd,
                         output logic [15:0] w1, output logic [13:0] w2);
        w1 = 16'h0000;
        w2 = 14'h0000;
        link_in.power_down_request_pin = ~pd;
        #3;
        link_in.cs_n = 1'b0;
        #400;
        // sclk stops after the last fall the caller asked for
        for (int k = 1; k <= n; k++) begin
            link_in.sclk = 1'b1;
            #100;
            if (k <= 16) w1[16-k] = sdo_line;
            else if (k <= 30) w2[30-k] = sdo_line;
            link_in.sclk = 1'b0;
            #100;
        end
        link_in.power_down_request_pin = pd;
        #100;
        link_in.cs_n = 1'b1;
        #100;
        link_in.power_down_request_pin = 1'b0;
        #(1000 + min_acquisition_time + 100);
    endtask

    // sclk pulse with cs high, wakes a 32-clock power-down
    task automatic wake();
        #100;
        link_in.sclk = 1'b1;
        #100;
        link_in.sclk = 1'b0;
    endtask
endmodule // asfpc_host

/* tb/testbench.sv */
// self-checking bench of the serial frame and power control block
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic result_valid = 1'b0;
    asfpc_pkg::asfpc_word_t result = '0;
    asfpc_pkg::asfpc_link_in_t link_in;
    asfpc_pkg::asfpc_link_out_t link_out;
    asfpc_pkg::asfpc_status_t status;
    logic result_ready;
    logic [15:0] w1;
    logic [13:0] w2;
    int err_total = 0;
    int check_count = 0;
    int abort_n = 0;
    int pd_n = 0;
    logic pd_q = 1'b0;
    logic clk_en = 1'b1;
    int samp_n = 0;
    int step_n = 0;

    always #12.5 sys_clk = ~sys_clk;

    asfpc_frame DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .link_in(link_in), .link_out(link_out),
        .result_valid(result_valid), .result_ready(result_ready),
        .result(result), .status(status)
    );

    asfpc_host host (
        .link_in(link_in), .sdo(link_out.sdo), .sdo_oe(link_out.sdo_oe)
    );

    // counts abort pulses and entries into power-down
    always @(posedge sys_clk) begin
        if (status.abort === 1'b1) abort_n++;
        if (status.sample === 1'b1) samp_n++;
        if (status.conv_step === 1'b1) step_n++;
        if (status.power_down === 1'b1 && pd_q !== 1'b1) pd_n++;
        pd_q <= status.power_down;
    end

    function automatic logic [13:0] wv(input logic [3:0] i);
        return {i, ~i, 6'h2d};
    endfunction

    function automatic logic [15:0] fw(input logic [3:0] i);
        return {wv(i), asfpc_pkg::PAD_ZERO};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic run(input int n, input logic pd);
        host.frame(n, pd, w1, w2);
    endtask

    task automatic test_reset();
        check({15'h0, link_out.sdo_oe}, 16'h0000);
        check({15'h0, result_ready}, 16'h0001);
        check({9'h0, status}, 16'h0001);
        $display("test reset done");
    endtask

    // fill the fifo until it refuses; host keeps sclk still meanwhile
    task automatic test_fill();
        for (int i = 0; i < 16; i++) begin
            result_valid = 1'b1;
            result.code = wv(4'(i));
            @(negedge sys_clk);
        end
        result.code = 14'h3fff;
        @(negedge sys_clk);
        check({15'h0, result_ready}, 16'h0000);
        result_valid = 1'b0;
        $display("test fill done");
    endtask

    task automatic test_frame16();
        int s;
        int t;
        s = samp_n;
        t = step_n;
        run(16, 1'b0);
        check(16'(samp_n - s), 16'h0001);
        check(16'(step_n - t), 16'h0010);
        check(w1, {asfpc_pkg::RESULT_RESET, asfpc_pkg::PAD_ZERO});
        check({15'h0, link_out.sdo_oe}, 16'h0000);
        run(16, 1'b0);
        check(w1, fw(4'h0));
        check({15'h0, result_ready}, 16'h0001);
        check(16'(pd_n), 16'h0000);
        $display("test frame16 done");
    endtask

    task automatic test_frame32();
        run(32, 1'b0);
        check(w1, fw(4'h1));
        check({2'h0, w2}, {2'h0, wv(4'h2)});
        check({15'h0, status.mode32}, 16'h0001);
        run(16, 1'b0);
        check(w1, 16'h0000);
        check({15'h0, status.mode32}, 16'h0000);
        $display("test frame32 done");
    endtask

    task automatic test_abort();
        int a;
        int t;
        a = abort_n;
        t = step_n;
        run(8, 1'b0);
        check(16'(abort_n - a), 16'h0001);
        check(16'(step_n - t), 16'h0008);
        check({15'h0, status.converting}, 16'h0000);
        run(16, 1'b0);
        run(16, 1'b0);
        check(w1, fw(4'h4));
        $display("test abort done");
    endtask

    task automatic test_pd16();
        run(16, 1'b1);
        check(w1, fw(4'h5));
        check(16'(pd_n), 16'h0000);
        run(16, 1'b0);
        check(w1, fw(4'h6));
        check(16'(pd_n), 16'h0001);
        check({14'h0, status.power_down, status.core_ready}, 16'h0001);
        $display("test pd16 done");
    endtask

    // low-rate style: 32-clock framing with power-down armed
    task automatic test_pd32();
        run(32, 1'b1);
        check(w1, fw(4'h7));
        check({2'h0, w2}, {2'h0, wv(4'h8)});
        run(32, 1'b0);
        check(w1, 16'h0000);
        check({2'h0, w2}, {2'h0, wv(4'h9)});
        check(16'(pd_n), 16'h0002);
        check({15'h0, status.power_down}, 16'h0001);
        host.wake();
        repeat (8) @(negedge sys_clk);
        check({14'h0, status.power_down, status.core_ready}, 16'h0000);
        repeat (48) @(negedge sys_clk);
        check({15'h0, status.core_ready}, 16'h0001);
        $display("test pd32 done");
    endtask

    // drain the fifo past empty; the held word repeats
    task automatic test_drain();
        for (int i = 0; i < 8; i++) begin
            run(16, 1'b0);
            if (i > 0) check(w1, fw(4'(i < 7 ? 9 + i : 15)));
        end
        check({15'h0, result_ready}, 16'h0001);
        $display("test drain done");
    endtask

    // clk_en low freezes the fifo; a word offered meanwhile must not land
    task automatic test_freeze();
        @(negedge sys_clk);
        clk_en = 1'b0;
        result_valid = 1'b1;
        result.code = wv(4'h3);
        repeat (4) @(negedge sys_clk);
        result_valid = 1'b0;
        clk_en = 1'b1;
        run(16, 1'b0);
        run(16, 1'b0);
        check(w1, fw(4'hf));
        $display("test freeze done");
    endtask

    initial begin
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        test_reset();
        test_fill();
        test_frame16();
        test_frame32();
        test_abort();
        test_pd16();
        test_pd32();
        test_drain();
        test_freeze();
        finish_test();
    end

    initial begin
        #1000000;
        err_total++;
        finish_test();
    end
endmodule // testbench
